// *** sysctl_mem_perf_regs.v ***
// memory parameter, performance counter and bus error registers of the system-control unit
`timescale 1ns/1ps
`include "sysctl_regs.vh"
module sysctl_mem_perf_regs #(
  parameter CNT_W = 32
) (
  // clock and cold reset
  input  wire                ref_clk,
  input  wire                srst,
  // register access port
  input  wire [`ADDR_W-1:0]  reg_addr,
  input  wire                reg_wr,
  input  wire                reg_rd,
  input  wire [31:0]         reg_wdata,
  output reg  [31:0]         reg_rdata,
  // sdram controller and delay line
  output wire                boot_alias_switch,
  output wire                power_down_request,
  output wire                exit_self_refresh_request,
  output wire                capture_clock_select,
  output wire [3:0]          coarse_delay_count,
  output wire [3:0]          fine_delay_count,
  input  wire [1:0]          coarse_phase_status,
  input  wire [1:0]          fine_phase_status,
  // cpu events, one bit per event code 0..7
  input  wire [7:0]          cpu_events,
  // system bus error sources
  input  wire                bus_error_resp,
  input  wire [31:0]         bus_error_addr,
  input  wire                watchdog_expired,
  input  wire                watchdog_error_enable,
  output wire                bus_error_irq_pending
);

  // control register state
  reg  [11:0]      mem_params_reg;
  reg  [11:0]      mem_params_next;
  reg  [3:0]       sel0_reg;
  reg  [3:0]       sel0_next;
  reg  [3:0]       sel1_reg;
  reg  [3:0]       sel1_next;
  reg              pause_reg;
  reg              pause_next;
  // bus error state
  reg              err_reg;
  reg              err_next;
  reg              ovf_reg;
  reg              ovf_next;
  reg              wdog_reg;
  reg              wdog_next;
  reg  [31:0]      err_addr_reg;
  reg  [31:0]      err_addr_next;
  // read path
  reg  [31:0]      rdata_next;
  // decoded accesses
  wire             wr_mem_params;
  wire             wr_perf_ctrl;
  wire             wr_err_status;
  wire             rd_perf_zero;
  wire             rd_perf_one;
  // counters
  wire [CNT_W-1:0] cnt0;
  wire [CNT_W-1:0] cnt1;
  wire             max0;
  wire             max1;
  wire             halve;
  // error sources
  wire             wdog_err;
  wire             any_err;
  wire             first_err;
  wire             clear_err;

  function hit;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // counters may be narrower than the bus word
  function [31:0] cnt_word;
    input [CNT_W-1:0] c;
    begin
      cnt_word            = 32'h0000_0000;
      cnt_word[CNT_W-1:0] = c;
    end
  endfunction

  // access decode
  assign wr_mem_params = reg_wr & hit(reg_addr, `OFS_SDRAM_CTRL_PARAMS);
  assign wr_perf_ctrl  = reg_wr & hit(reg_addr, `OFS_PERF_CTRL);
  assign wr_err_status = reg_wr & hit(reg_addr, `OFS_BUS_ERROR_STATUS);
  assign rd_perf_zero  = reg_rd & hit(reg_addr, `OFS_PERF_ZERO);
  assign rd_perf_one   = reg_rd & hit(reg_addr, `OFS_PERF_ONE);

  // controller and delay line inputs come straight from the register
  assign boot_alias_switch         = mem_params_reg[`MP_ALIAS_BIT];
  assign power_down_request        = mem_params_reg[`MP_PWRDN_BIT];
  assign exit_self_refresh_request = mem_params_reg[`MP_EXIT_SR_BIT];
  assign capture_clock_select      = mem_params_reg[`MP_CAPSEL_BIT];
  assign coarse_delay_count        = mem_params_reg[`MP_COARSE_LSB +: 4];
  assign fine_delay_count          = mem_params_reg[`MP_FINE_LSB +: 4];

  // control register next values
  always @*
  begin
    mem_params_next = mem_params_reg;
    sel0_next       = sel0_reg;
    sel1_next       = sel1_reg;
    pause_next      = pause_reg;
    if (wr_mem_params)
      mem_params_next = reg_wdata[11:0];
    if (wr_perf_ctrl)
    begin
      // reserved selects are kept and read back; they just count nothing
      sel0_next  = reg_wdata[`PC_SEL0_LSB +: 4];
      sel1_next  = reg_wdata[`PC_SEL1_LSB +: 4];
      pause_next = reg_wdata[`PC_PAUSE_BIT];
    end
  end

  always @(posedge ref_clk)
  begin
    if (srst)
      mem_params_reg <= `MP_RESET;
    else
      mem_params_reg <= mem_params_next;
  end

  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      sel0_reg  <= `PC_SEL0_RESET;
      sel1_reg  <= `PC_SEL1_RESET;
      pause_reg <= 1'b0;
    end
    else
    begin
      sel0_reg  <= sel0_next;
      sel1_reg  <= sel1_next;
      pause_reg <= pause_next;
    end
  end

  // halving on a shared max keeps the ratio of the two counts meaningful
  assign halve = max0 | max1;

  perf_counter #(
    .WIDTH (CNT_W)
  ) u_cnt0 (
    .ref_clk    (ref_clk),
    .srst       (srst),
    .event_sel  (sel0_reg),
    .pause      (pause_reg),
    .events     (cpu_events),
    .read_clear (rd_perf_zero),
    .halve      (halve),
    .count_reg  (cnt0),
    .at_max     (max0)
  );

  perf_counter #(
    .WIDTH (CNT_W)
  ) u_cnt1 (
    .ref_clk    (ref_clk),
    .srst       (srst),
    .event_sel  (sel1_reg),
    .pause      (pause_reg),
    .events     (cpu_events),
    .read_clear (rd_perf_one),
    .halve      (halve),
    .count_reg  (cnt1),
    .at_max     (max1)
  );

  // bus error sources; watchdog expiry only counts when enabled
  assign wdog_err  = watchdog_expired & watchdog_error_enable;
  assign any_err   = bus_error_resp | wdog_err;
  assign clear_err = wr_err_status & reg_wdata[`BE_ERR_BIT];
  // an error while nothing is held, or in the clearing cycle, is a first error
  assign first_err = any_err & (~err_reg | clear_err);

  // status next values; set wins over a clear in the same cycle
  always @*
  begin
    err_next  = err_reg;
    ovf_next  = ovf_reg;
    wdog_next = wdog_reg;
    if (first_err)
    begin
      err_next  = 1'b1;
      ovf_next  = 1'b0;
      wdog_next = ~bus_error_resp;
    end
    else if (clear_err)
    begin
      err_next  = 1'b0;
      ovf_next  = 1'b0;
      wdog_next = 1'b0;
    end
    // later errors only mark overflow; the first one's details stay
    else if (any_err)
      ovf_next = 1'b1;
  end

  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      err_reg  <= 1'b0;
      ovf_reg  <= 1'b0;
      wdog_reg <= 1'b0;
    end
    else
    begin
      err_reg  <= err_next;
      ovf_reg  <= ovf_next;
      wdog_reg <= wdog_next;
    end
  end

  // address of the first error only; later errors leave it alone
  always @*
  begin
    err_addr_next = err_addr_reg;
    if (first_err)
      err_addr_next = bus_error_addr;
  end

  always @(posedge ref_clk)
  begin
    if (srst)
      err_addr_reg <= 32'h0000_0000;
    else
      err_addr_reg <= err_addr_next;
  end

  assign bus_error_irq_pending = err_reg;

  // read data mux; anything not mapped reads as zero
  always @*
  begin
    rdata_next = 32'h0000_0000;
    case (reg_addr)
      `OFS_SDRAM_CTRL_PARAMS:
      begin
        rdata_next[11:0]                   = mem_params_reg;
        rdata_next[`MP_COARSE_PH_LSB +: 2] = coarse_phase_status;
        rdata_next[`MP_FINE_PH_LSB +: 2]   = fine_phase_status;
      end
      `OFS_PERF_CTRL:
      begin
        rdata_next[`PC_SEL0_LSB +: 4] = sel0_reg;
        rdata_next[`PC_SEL1_LSB +: 4] = sel1_reg;
        rdata_next[`PC_PAUSE_BIT]     = pause_reg;
      end
      `OFS_PERF_ZERO:
        rdata_next = cnt_word(cnt0);
      `OFS_PERF_ONE:
        rdata_next = cnt_word(cnt1);
      `OFS_BUS_ERROR_STATUS:
      begin
        rdata_next[`BE_ERR_BIT]  = err_reg;
        rdata_next[`BE_OVF_BIT]  = ovf_reg;
        rdata_next[`BE_WDOG_BIT] = wdog_reg;
      end
      `OFS_BUS_ERROR_ADDR:
        rdata_next = err_addr_reg;
      default:
        rdata_next = 32'h0000_0000;
    endcase
  end

  // read data holds between reads so the master may pick it up late
  always @(posedge ref_clk)
  begin
    if (srst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
      reg_rdata <= rdata_next;
  end

endmodule // sysctl_mem_perf_regs

// *** sysctl_regs.vh ***
// register offsets, field positions and reset values for the memory, performance and bus error registers
`ifndef SYSCTL_REGS_VH
`define SYSCTL_REGS_VH

`define ADDR_W                 16
`define OFS_SDRAM_CTRL_PARAMS  16'h0040
`define OFS_PERF_CTRL          16'h0044
`define OFS_PERF_ZERO          16'h0048
`define OFS_PERF_ONE           16'h004c
`define OFS_BUS_ERROR_STATUS   16'h0050
`define OFS_BUS_ERROR_ADDR     16'h0054

`define MP_ALIAS_BIT           0
`define MP_PWRDN_BIT           1
`define MP_EXIT_SR_BIT         2
`define MP_CAPSEL_BIT          3
`define MP_COARSE_LSB          4
`define MP_FINE_LSB            8
`define MP_COARSE_PH_LSB       16
`define MP_FINE_PH_LSB         18
`define MP_RESET               12'h000

`define PC_SEL0_LSB            0
`define PC_SEL1_LSB            4
`define PC_PAUSE_BIT           8
`define PC_SEL0_RESET          4'h0
`define PC_SEL1_RESET          4'h3

`define BE_ERR_BIT             0
`define BE_OVF_BIT             1
`define BE_WDOG_BIT            2

`endif

// *** perf_counter.v ***
// one WIDTH-bit performance counter (32 by default) with event select, read-clear and joint halving
`timescale 1ns/1ps
module perf_counter #(
  parameter WIDTH = 32
) (
  // clock and reset
  input  wire             ref_clk,
  input  wire             srst,
  // control
  input  wire [3:0]       event_sel,
  input  wire             pause,
  input  wire [7:0]       events,
  input  wire             read_clear,
  input  wire             halve,
  // state
  output reg  [WIDTH-1:0] count_reg,
  output wire             at_max
);

  reg  [WIDTH-1:0] count_next;
  wire             hit;

  // reserved selects count nothing
  assign hit    = event_sel[3] ? 1'b0 : events[event_sel[2:0]];
  assign at_max = &count_reg;

  always @*
  begin
    count_next = count_reg;
    if (halve)
      count_next = {1'b0, count_reg[WIDTH-1:1]};
    else if (!pause && hit)
      count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    // read wins: an event during the read is dropped with the old value
    if (read_clear)
      count_next = {WIDTH{1'b0}};
  end

  always @(posedge ref_clk)
  begin
    if (srst)
      count_reg <= {WIDTH{1'b0}};
    else
      count_reg <= count_next;
  end

endmodule // perf_counter

// *** sysctl_regs_chk_assertions.sv ***
// assertion checker for the memory, performance and bus error registers
`timescale 1ns/1ps
module sysctl_regs_chk (
  // clock, reset and register port
  input wire        ref_clk,
  input wire        srst,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [15:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire [31:0] reg_rdata,
  // memory controller side
  input wire        boot_alias_switch,
  input wire        power_down_request,
  input wire        exit_self_refresh_request,
  input wire        capture_clock_select,
  input wire [3:0]  coarse_delay_count,
  input wire [3:0]  fine_delay_count,
  input wire [1:0]  coarse_phase_status,
  input wire [1:0]  fine_phase_status,
  // events and bus errors
  input wire [7:0]  cpu_events,
  input wire        bus_error_resp,
  input wire        watchdog_expired,
  input wire        watchdog_error_enable,
  input wire        bus_error_irq_pending,
  input wire [31:0] bus_error_addr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire wr40 = reg_wr && reg_addr == 16'h0040;
  wire no_err = !bus_error_resp && !watchdog_expired;
  AST_CTRL_BITS: assert property (wr40 |=>
    {capture_clock_select, exit_self_refresh_request, power_down_request, boot_alias_switch} == $past(reg_wdata[3:0]))
    else $error("control bits wrong");
  AST_DELAYS: assert property (wr40 |=> {fine_delay_count, coarse_delay_count} == $past(reg_wdata[11:4]))
    else $error("delay counts wrong");
  AST_PHASE: assert property (reg_rd && reg_addr == 16'h0040 |=>
    reg_rdata[31:12] == {12'h000, $past(fine_phase_status), $past(coarse_phase_status), 4'h0})
    else $error("phase status wrong");
  AST_PERF_RES: assert property (reg_rd && reg_addr == 16'h0044 |=> reg_rdata[31:9] == 23'h0)
    else $error("reserved bits set");
  AST_UNMAPPED: assert property (reg_rd && reg_addr == 16'h0080 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  AST_ERR_SETS: assert property (bus_error_resp |=> bus_error_irq_pending)
    else $error("error not recorded");
  AST_WD_OFF: assert property (watchdog_expired && !watchdog_error_enable && !bus_error_resp
    && !bus_error_irq_pending |=> !bus_error_irq_pending)
    else $error("disabled watchdog recorded");
  AST_WD_ON: assert property (watchdog_expired && watchdog_error_enable |=> bus_error_irq_pending)
    else $error("watchdog error lost");
  AST_CLEAR: assert property (reg_wr && reg_addr == 16'h0050 && reg_wdata[0] && no_err
    |=> !bus_error_irq_pending)
    else $error("error not cleared");
  AST_IRQ_HOLD: assert property (bus_error_irq_pending && !(reg_wr && reg_addr == 16'h0050 && reg_wdata[0])
    |=> bus_error_irq_pending)
    else $error("pending flag dropped");
  AST_ERR_READ: assert property (reg_rd && reg_addr == 16'h0050 |=>
    reg_rdata[31:3] == 29'h0 && reg_rdata[0] == $past(bus_error_irq_pending))
    else $error("error status read wrong");
endmodule // sysctl_regs_chk
bind sysctl_mem_perf_regs sysctl_regs_chk i_sysctl_regs_chk (
  .ref_clk                   (ref_clk),
  .srst                      (srst),
  .reg_wr                    (reg_wr),
  .reg_rd                    (reg_rd),
  .reg_addr                  (reg_addr),
  .reg_wdata                 (reg_wdata),
  .reg_rdata                 (reg_rdata),
  .boot_alias_switch         (boot_alias_switch),
  .power_down_request        (power_down_request),
  .exit_self_refresh_request (exit_self_refresh_request),
  .capture_clock_select      (capture_clock_select),
  .coarse_delay_count        (coarse_delay_count),
  .fine_delay_count          (fine_delay_count),
  .coarse_phase_status       (coarse_phase_status),
  .fine_phase_status         (fine_phase_status),
  .cpu_events                (cpu_events),
  .bus_error_resp            (bus_error_resp),
  .watchdog_expired          (watchdog_expired),
  .watchdog_error_enable     (watchdog_error_enable),
  .bus_error_irq_pending     (bus_error_irq_pending),
  .bus_error_addr            (bus_error_addr)
);

// *** test_sysctl_mem_perf_regs.sv ***
// self-checking bench for the memory, performance and bus error registers
`timescale 1ns/1ps
module test_sysctl_mem_perf_regs;
  reg         ref_clk = 1'h0, srst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
  reg         bus_error_resp = 1'h0, watchdog_expired = 1'h0, watchdog_error_enable = 1'h0;
  reg  [15:0] reg_addr = 16'h0;
  reg  [31:0] reg_wdata = 32'h0, bus_error_addr = 32'h1234_5678, got;
  reg  [7:0]  cpu_events = 8'h0;
  reg  [1:0]  coarse_phase_status = 2'h1, fine_phase_status = 2'h2;
  wire [31:0] reg_rdata;
  wire [3:0]  coarse_delay_count, fine_delay_count;
  wire        boot_alias_switch, power_down_request, exit_self_refresh_request, capture_clock_select;
  wire        bus_error_irq_pending;
  integer     mismatches = 0, samples_checked = 0, i;
  wire [11:0] ctrl = {fine_delay_count, coarse_delay_count, capture_clock_select,
                      exit_self_refresh_request, power_down_request, boot_alias_switch};
  // 8-bit counters so the halving point is reached in a few hundred cycles
  sysctl_mem_perf_regs #(
    .CNT_W (8)
  ) i_sysctl_mem_perf_regs (
    .ref_clk                   (ref_clk),
    .srst                      (srst),
    .reg_addr                  (reg_addr),
    .reg_wr                    (reg_wr),
    .reg_rd                    (reg_rd),
    .reg_wdata                 (reg_wdata),
    .reg_rdata                 (reg_rdata),
    .boot_alias_switch         (boot_alias_switch),
    .power_down_request        (power_down_request),
    .exit_self_refresh_request (exit_self_refresh_request),
    .capture_clock_select      (capture_clock_select),
    .coarse_delay_count        (coarse_delay_count),
    .fine_delay_count          (fine_delay_count),
    .coarse_phase_status       (coarse_phase_status),
    .fine_phase_status         (fine_phase_status),
    .cpu_events                (cpu_events),
    .bus_error_resp            (bus_error_resp),
    .bus_error_addr            (bus_error_addr),
    .watchdog_expired          (watchdog_expired),
    .watchdog_error_enable     (watchdog_error_enable),
    .bus_error_irq_pending     (bus_error_irq_pending)
  );
  always #50 ref_clk = ~ref_clk;
  task chk(input [31:0] g, input [31:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e)
      begin
        mismatches = mismatches + 1;
        $display("unexpected value at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  task acc(input w, input [15:0] a, input [31:0] d);
    begin
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = w;
      reg_rd = !w;
      @(negedge ref_clk);
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      got = reg_rdata;
    end
  endtask
  task ev(input [7:0] m, input integer n);
    begin
      @(negedge ref_clk);
      cpu_events = m;
      repeat (n) @(negedge ref_clk);
      cpu_events = 8'h0;
    end
  endtask
  task err(input wd);
    begin
      @(negedge ref_clk);
      watchdog_expired = wd;
      bus_error_resp = !wd;
      @(negedge ref_clk);
      watchdog_expired = 1'h0;
      bus_error_resp = 1'h0;
    end
  endtask
  task t_regs;
    begin
      chk(ctrl, 32'h0);
      acc(0, 16'h0044, 0); chk(got, 32'h30);
      acc(1, 16'h0040, 32'hffff_ffff); chk(ctrl, 32'hfff);
      acc(0, 16'h0040, 0); chk(got, 32'h0009_0fff);
      acc(1, 16'h0040, 32'h5a5); chk(ctrl, 32'h5a5);
      acc(0, 16'h0080, 0); chk(got, 32'h0);
      $display("register fields done");
    end
  endtask
  task t_perf;
    begin
      for (i = 0; i < 9; i = i + 1)
      begin
        acc(1, 16'h0044, 32'h30 | i);
        acc(0, 16'h0048, 0);
        ev(i < 8 ? 8'h1 << i : 8'hff, i + 1);
        acc(0, 16'h0048, 0); chk(got, i < 8 ? i + 1 : 0);
        acc(0, 16'h0048, 0); chk(got, 32'h0);
      end
      acc(1, 16'h0044, 32'h0);
      ev(8'h1, 4);
      acc(1, 16'h0048, 32'h0);
      acc(0, 16'h0048, 0); chk(got, 32'h4);
      acc(1, 16'h0044, 32'h100);
      ev(8'h1, 5);
      acc(0, 16'h0048, 0); chk(got, 32'h0);
      acc(1, 16'h0044, 32'h10);
      acc(0, 16'h004c, 0);
      ev(8'h3, 10);
      ev(8'h1, 246);
      acc(0, 16'h0048, 0); chk(got, 32'h7f);
      acc(0, 16'h004c, 0); chk(got, 32'h5);
      $display("counters done");
    end
  endtask
  task t_err;
    begin
      err(0);
      acc(0, 16'h0050, 0); chk(got, 32'h1);
      chk(bus_error_irq_pending, 1);
      bus_error_addr = 32'h9abc_def0;
      err(0);
      acc(0, 16'h0050, 0); chk(got, 32'h3);
      acc(0, 16'h0054, 0); chk(got, 32'h1234_5678);
      acc(1, 16'h0050, 32'h6);
      acc(0, 16'h0050, 0); chk(got, 32'h3);
      acc(1, 16'h0050, 32'h1);
      acc(0, 16'h0050, 0); chk(got, 32'h0);
      err(1);
      acc(0, 16'h0050, 0); chk(got, 32'h0);
      watchdog_error_enable = 1'h1;
      err(1);
      acc(0, 16'h0050, 0); chk(got, 32'h5);
      $display("bus errors done");
    end
  endtask
  // cold reset in mid-run must bring every register back to its reset value
  task t_reset;
    begin
      acc(1, 16'h0040, 32'h0000_0abc);
      chk(ctrl, 32'habc);
      acc(1, 16'h0044, 32'h0000_0021);
      ev(8'h6, 3);
      err(0);
      @(negedge ref_clk);
      srst = 1'h1;
      repeat (4) @(negedge ref_clk);
      srst = 1'h0;
      chk(ctrl, 32'h0);
      chk(bus_error_irq_pending, 0);
      acc(0, 16'h0044, 0);
      chk(got, 32'h30);
      acc(0, 16'h0048, 0);
      chk(got, 32'h0);
      acc(0, 16'h004c, 0);
      chk(got, 32'h0);
      acc(0, 16'h0050, 0);
      chk(got, 32'h0);
      acc(0, 16'h0054, 0);
      chk(got, 32'h0);
      $display("cold reset done");
    end
  endtask
  task complete_run;
    begin
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial
  begin
    #5000000;
    mismatches = mismatches + 1;
    complete_run;
  end
  initial
  begin
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    srst = 1'h0;
    t_regs;
    t_perf;
    t_err;
    t_reset;
    complete_run;
  end
endmodule // test_sysctl_mem_perf_regs
